// file: design/stc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Sixteen-bit timer/counter with register port
module stc_timer
  import stc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       porReset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire logic       externalCountInput,
  input  wire logic       crystalInPin,
  input  wire logic       sleepActive,
  input  wire logic [3:0] matchModeSelect,
  input  wire logic       compareMatch,
  input  wire logic       converterEnable,
  output logic            crystalOutPin,
  output logic            crystalAmpEnable,
  output logic            conversionStart,
  output logic            irq
);
  logic [7:0] countLow;        // Count low byte
  logic [7:0] countHigh;       // Count high byte
  logic [7:0] control;         // Control register
  logic [7:0] flags;           // Sticky flag register
  logic [7:0] enables;         // Interrupt mask
  logic [1:0] instrPhase;      // Oscillator clocks in instruction
  logic [2:0] prescale;        // Prescaler count
  logic       armed;           // Falling edge seen since enable
  logic       tick;            // Raw count event
  logic       advance;         // Prescaled count event
  logic       specialEvent;    // Trigger from compare unit
  logic       wrLow;           // Low byte write
  logic       wrHigh;          // High byte write
  logic [15:0] nextCount;      // Incremented count
  logic       wraps;           // Count at maximum this advance
  stc_edge_if pinEdges ();     // Filtered pin

  // Operating notes
  // Timer mode: one raw tick per instruction cycle
  // Instruction cycle: four clock periods of this block
  // Counter mode: rising pin edges after a falling edge
  // Arming drops whenever counting stops or source flips
  // Pin path: three flops, level taken when stages agree
  // Bypass path: second stage taken directly
  // Bypass saves one clock of pin latency
  // Edge pulses come from the accepted level only
  // Prescaler: divides raw ticks by one, two, four or eight
  // Prescaler cleared by either count byte write
  // Prescaler keeps its value across enable changes
  // Divide ratio change applies at the next tick
  // Count bytes: written independently, no shadow latch
  // Low byte: among resets, cleared by the asynchronous reset only, not by power-on reset
  // High byte: among resets, cleared only by power-on reset
  // High byte holds through ordinary resets
  // Reads of the count are not atomic across bytes
  // Software must handle a carry between byte reads
  // Special event: compare unit matched in its trigger mode
  // Special event clears both bytes in the same cycle
  // Count write wins over a same-cycle special event
  // A low byte write also shields the high byte
  // Special event ignored with an unsynchronised pin
  // Compare unit does its own match against its pair
  // That match makes the compare pair a period
  // Overflow: count wraps from all ones to zero
  // Overflow sets the sticky flag bit
  // Special event clears do not set the flag
  // Flag cleared by writing zero, kept by writing one
  // A wrap in the clearing cycle keeps the flag set
  // Interrupt: level output, flag and mask both set
  // Mask change takes effect in the next cycle
  // Crystal amplifier: straight from the control bit
  // Sleep does not stop the crystal amplifier
  // Sleep input is otherwise unused here
  // Control bits 7-6: never stored, read as zero
  // Register port: one-cycle strobes, no wait states
  // Read data: stands for the one cycle after the strobe
  // Read data: zero in every other cycle
  // Unmapped reads return zero
  // Unmapped writes are dropped
  // Back-to-back strobes are accepted
  // Hazards
  // Each pin level must stand at least two clocks
  // Narrower pin pulses may be missed entirely
  // A pin already low at enable still needs a fresh fall
  // Asynchronous reset clears control, so counting stops
  // Power-on reset input is synchronous to this clock
  // Power-on reset must stand for at least one edge
  // High byte is unknown until the first power-on reset
  // Compare mode code is taken from the compare unit
  // Conversion start is a one-cycle combinational pulse
  // It follows the compare unit's match pulse

  // Pin filter instance
  stc_pin_sync u_sync (
    .clock  (clock),
    .rst    (rst),
    .pin    (externalCountInput),
    .bypass (control[STC_BIT_SYNCBY] & control[STC_BIT_SOURCE]),
    .edge_o (pinEdges)
  );

  // Divider ratio mask from the two-bit field
  function automatic logic [2:0] stc_div_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: stc_div_mask = 3'h0;
      2'h1: stc_div_mask = 3'h1;
      2'h2: stc_div_mask = 3'h3;
      2'h3: stc_div_mask = 3'h7;
    endcase
  endfunction : stc_div_mask

  // Write strobe aimed at one register address
  function automatic logic stc_write_hit(
    input logic       strobe,
    input logic [7:0] where,
    input logic [7:0] target
  );
    stc_write_hit = strobe && (where == target);
  endfunction : stc_write_hit

  // Crystal amplifier follows enable, not sleep
  always_comb begin
    crystalAmpEnable = control[STC_BIT_OSCEN];
    crystalOutPin    = control[STC_BIT_OSCEN] & ~crystalInPin;
  end

  // Instruction cycle phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      instrPhase <= 2'h0;
    end else begin
      instrPhase <= instrPhase + 2'h1;
    end
  end

  // Falling edge arming in counter mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (!control[STC_BIT_ENABLE] || !control[STC_BIT_SOURCE]) begin
      armed <= 1'b0;
    end else if (pinEdges.fall) begin
      armed <= 1'b1;
    end
  end

  // Raw tick selection
  always_comb begin
    if (control[STC_BIT_SOURCE]) begin
      tick = armed & pinEdges.rise;
    end else begin
      tick = (instrPhase == STC_INSTR_LAST);
    end
    tick = tick & control[STC_BIT_ENABLE];
  end

  // Prescaler
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale <= 3'h0;
    end else if (wrLow || wrHigh) begin
      prescale <= 3'h0;
    end else if (tick) begin
      prescale <= (prescale >= stc_div_mask(control[STC_DIV_LSB +: 2])) ? 3'h0
                                                                         : prescale + 3'h1;
    end
  end

  // Prescaled count event once the divider has rolled
  always_comb begin
    advance = tick && (prescale >= stc_div_mask(control[STC_DIV_LSB +: 2]));
  end

  // Count byte write decodes
  always_comb begin
    wrLow  = stc_write_hit(wrStrobe, addr, STC_ADDR_CNT_LO);
    wrHigh = stc_write_hit(wrStrobe, addr, STC_ADDR_CNT_HI);
  end

  // Next count and wrap detection
  always_comb begin
    nextCount = {countHigh, countLow} + 16'h0001;
    wraps     = advance && ({countHigh, countLow} == 16'hFFFF);
  end

  // Special event, refused when counting asynchronously
  always_comb begin
    specialEvent = (matchModeSelect == STC_MODE_SPECIAL) && compareMatch
                   && !(control[STC_BIT_SOURCE] && control[STC_BIT_SYNCBY]);
  end

  // Conversion start rides on the special event
  always_comb begin
    conversionStart = specialEvent && converterEnable;
  end

  // Level interrupt from flag and mask
  always_comb begin
    irq = flags[STC_BIT_OVF] & enables[STC_BIT_OVF];
  end

  // Count low byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      countLow <= STC_CNT_RESET;
    end else if (wrLow) begin
      countLow <= wrData;
    end else if (specialEvent) begin
      countLow <= STC_CNT_RESET;
    end else if (advance) begin
      countLow <= nextCount[7:0];
    end
  end

  // Count high byte, among resets cleared only by power-on reset
  always_ff @(posedge clock) begin
    if (porReset) begin
      countHigh <= STC_CNT_RESET;
    end else if (wrHigh) begin
      countHigh <= wrData;
    end else if (specialEvent && !wrLow) begin
      countHigh <= STC_CNT_RESET;
    end else if (advance && !wrLow) begin
      countHigh <= nextCount[15:8];
    end
  end

  // Control register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      control <= STC_CTRL_RESET;
    end else if (stc_write_hit(wrStrobe, addr, STC_ADDR_CTRL)) begin
      // Unimplemented top bits never stored
      control <= wrData & STC_CTRL_MASK;
    end
  end

  // Interrupt mask register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables <= STC_EN_RESET;
    end else if (stc_write_hit(wrStrobe, addr, STC_ADDR_ENABLES)) begin
      // Whole mask byte taken as written
      enables <= wrData;
    end
  end

  // Sticky flag: set wins, write zero clears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags <= STC_FLAGS_RESET;
    end else begin
      if (stc_write_hit(wrStrobe, addr, STC_ADDR_FLAGS)) begin
        // Write zero clears, one keeps
        flags <= wrData & flags;
      end
      if (wraps) begin
        // Later assignment, so the set wins
        flags[STC_BIT_OVF] <= 1'b1;
      end
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      unique case (addr)
        STC_ADDR_FLAGS:   rdData <= flags;
        STC_ADDR_CNT_LO:  rdData <= countLow;
        STC_ADDR_CNT_HI:  rdData <= countHigh;
        STC_ADDR_CTRL:    rdData <= control & STC_CTRL_MASK;
        STC_ADDR_ENABLES: rdData <= enables;
        default:          rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end
endmodule : stc_timer
`default_nettype wire

// file: common/stc_pkg.sv
// Contract
// - Sixteen-bit count in two readable writable bytes
// - Control bit 0 runs or stops counting
// - Control bit 1 picks pin or instruction clock
// - Advance per instruction cycle or rising edge
// - Bits 5-4 pick divide by 1,2,4,8
// - Bit 2 bypasses pin synchronisation when external
// - Bit 3 switches crystal amplifier on or off
// - Crystal keeps running during sleep
// - Counter mode waits for first falling edge
// - Wrap to zero latches overflow flag
// - Interrupt only while overflow enable set
// - Special-event trigger clears count, starts conversion
// - Trigger reset unreliable in asynchronous counter mode
// - Software count write beats trigger reset
// - Compare pair acts as period in special-event
// - Control bits 7-6 read as zero
// - High byte kept through non-power resets
package stc_pkg;
  // Register offsets
  localparam logic [7:0] STC_ADDR_FLAGS   = 8'h0C;
  localparam logic [7:0] STC_ADDR_CNT_LO  = 8'h0E;
  localparam logic [7:0] STC_ADDR_CNT_HI  = 8'h0F;
  localparam logic [7:0] STC_ADDR_CTRL    = 8'h10;
  localparam logic [7:0] STC_ADDR_ENABLES = 8'h8C;
  // Control and flag field positions
  localparam int STC_BIT_ENABLE = 0;
  localparam int STC_BIT_SOURCE = 1;
  localparam int STC_BIT_SYNCBY = 2;
  localparam int STC_BIT_OSCEN  = 3;
  localparam int STC_DIV_LSB    = 4;
  localparam int STC_BIT_OVF    = 0;
  // Reset values and control mask
  localparam logic [7:0] STC_CTRL_RESET  = 8'h00;
  localparam logic [7:0] STC_CTRL_MASK   = 8'h3F;
  localparam logic [7:0] STC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] STC_EN_RESET    = 8'h00;
  localparam logic [7:0] STC_CNT_RESET   = 8'h00;
  // Compare mode that triggers the special event
  localparam logic [3:0] STC_MODE_SPECIAL = 4'hB;
  // Instruction cycle is four oscillator clocks
  localparam logic [1:0] STC_INSTR_LAST = 2'h3;
endpackage : stc_pkg

// file: common/stc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
// Filtered external input travelling into the core
interface stc_edge_if;
  logic level;    // Agreed pin level
  logic rise;     // Rising edge pulse
  logic fall;     // Falling edge pulse
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : stc_edge_if
`default_nettype wire

// file: design/stc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin sampler with edge detection
module stc_pin_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic bypass,
  stc_edge_if.src   edge_o
);
  logic s1;       // First stage, only read by s2
  logic s2;       // Second stage
  logic s3;       // Third stage
  logic agreed;   // Accepted level
  logic fast;     // Two-stage level for bypass path
  logic prevAgreed; // Accepted level one clock back
  // Sampling chain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Bypass takes the second stage directly, one cycle earlier
  always_comb fast = s2;
  // Accepted level updates when stages agree, or every clock in bypass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      agreed <= 1'b0;
    end else if (bypass) begin
      agreed <= fast;
    end else if (s2 == s3) begin
      agreed <= s3;
    end
  end
  // Accepted level delayed for edge detection, idle low like the pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prevAgreed <= 1'b0;
    end else begin
      prevAgreed <= agreed;
    end
  end
  // Edge pulses from accepted level change
  always_comb begin
    edge_o.level = agreed;
    edge_o.rise  = agreed & ~prevAgreed;
    edge_o.fall  = ~agreed & prevAgreed;
  end
endmodule : stc_pin_sync
`default_nettype wire

// file: bench/stc_timer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks for the timer
module stc_timer_asserts
  import stc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStrobe,
  input wire logic       rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic [3:0] matchModeSelect,
  input wire logic       compareMatch,
  input wire logic       converterEnable,
  input wire logic       crystalAmpEnable,
  input wire logic       conversionStart,
  input wire logic       irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Write then read of one place
  sequence s_wr_rd(logic [7:0] a);
    wrStrobe && addr == a ##1 rdStrobe && addr == a;
  endsequence
  a_ctrl_readback: assert property (
    s_wr_rd(STC_ADDR_CTRL) |=> rdData == ($past(wrData, 2) & STC_CTRL_MASK))
    else $error("control readback wrong");
  a_ctrl_top_zero: assert property (
    rdStrobe && addr == STC_ADDR_CTRL |=> rdData[7:6] == 2'h0)
    else $error("control top bits set");
  a_idle_rd_zero: assert property (
    !rdStrobe |=> rdData == 8'h00)
    else $error("read data without strobe");
  a_en_readback: assert property (
    s_wr_rd(STC_ADDR_ENABLES) |=> rdData[0] == |($past(wrData, 2) & 8'h01))
    else $error("enable readback wrong");
  a_irq_mask_off: assert property (
    wrStrobe && addr == STC_ADDR_ENABLES && !wrData[0] |=> !irq)
    else $error("irq while masked");
  a_conv_cause: assert property (
    conversionStart |-> compareMatch && converterEnable
      && matchModeSelect == STC_MODE_SPECIAL)
    else $error("conversion start without cause");
  a_amp_follow: assert property (
    wrStrobe && addr == STC_ADDR_CTRL |=> crystalAmpEnable == |($past(wrData) & 8'h08))
    else $error("amplifier not following control");
  a_amp_hold: assert property (
    !wrStrobe |=> $stable(crystalAmpEnable))
    else $error("amplifier changed without write");
endmodule : stc_timer_asserts
`default_nettype wire

// file: bench/stc_ext_source.sv
`timescale 1ns/1ps
`default_nettype none
// External count source on the pin
module stc_ext_source (
  input  wire logic clock,
  output logic      pin
);
  // Pin starts low
  initial pin = 1'b0;
  // Set one level and hold it six clocks
  task automatic drive(input logic lvl);
    @(posedge clock);
    pin <= lvl;
    repeat (6) @(posedge clock);
  endtask : drive
  // Full low then high cycles
  task automatic pulses(input int n);
    repeat (n) begin
      drive(1'b0);
      drive(1'b1);
    end
  endtask : pulses
endmodule : stc_ext_source
`default_nettype wire

// file: bench/test_stc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin badCount++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_stc_timer;
  import stc_pkg::*;
  logic       clock, rst, porReset, wrStrobe, rdStrobe, sleepActive, compareMatch;
  logic       converterEnable, crystalInPin, pin, crystalOutPin, crystalAmpEnable;
  logic       conversionStart, irq, c;
  logic [7:0] addr, wrData, rdData, v, w;
  logic [3:0] matchModeSelect;
  int         badCount, checksDone;
  stc_timer dut (.clock(clock), .rst(rst), .porReset(porReset), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .externalCountInput(pin), .crystalInPin(crystalInPin), .sleepActive(sleepActive),
    .matchModeSelect(matchModeSelect), .compareMatch(compareMatch),
    .converterEnable(converterEnable), .crystalOutPin(crystalOutPin),
    .crystalAmpEnable(crystalAmpEnable), .conversionStart(conversionStart), .irq(irq));
  stc_ext_source ext (.clock(clock), .pin(pin));
  // 50 ns clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask : wr
  // Read, data taken the cycle after
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    @(negedge clock);
    v = rdData;
  endtask : rd
  // Compare-unit pulse, start flag caught mid-cycle
  task automatic trig(input logic [3:0] m);
    @(posedge clock);
    matchModeSelect <= m;
    compareMatch <= 1'b1;
    @(negedge clock);
    c = conversionStart;
    @(posedge clock);
    compareMatch <= 1'b0;
  endtask : trig
  // Verdict and stop
  task automatic endSim;
    $display("checks %0d errors %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : endSim
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    badCount++;
    endSim();
  end
  // Main sequence
  initial begin
    {porReset, wrStrobe, rdStrobe, sleepActive, compareMatch} = 5'h00;
    {converterEnable, crystalInPin, addr, wrData, matchModeSelect} = 22'h0;
    rst = 1'b1;
    porReset = 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    porReset <= 1'b0;
    foreach (w[i]) if (i < 4) begin
      rd(i == 0 ? STC_ADDR_FLAGS : i == 1 ? STC_ADDR_CTRL : i == 2 ? STC_ADDR_ENABLES : 8'h0E);
      `CHK(v, 8'h00)
    end
    wr(STC_ADDR_CTRL, 8'hFF);
    sleepActive <= 1'b1;
    rd(STC_ADDR_CTRL);
    `CHK(v, 8'h3F)
    `CHK(crystalAmpEnable, 1'b1)
    rd(8'h00);
    `CHK(v, 8'h00)
    wr(STC_ADDR_CNT_HI, 8'h5A);
    wr(STC_ADDR_CNT_LO, 8'hA5);
    rd(STC_ADDR_CNT_LO);
    `CHK(v, 8'hA5)
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd(STC_ADDR_CNT_HI);
    `CHK(v, 8'h5A)
    porReset <= 1'b1;
    @(posedge clock);
    porReset <= 1'b0;
    rd(STC_ADDR_CNT_HI);
    `CHK(v, 8'h00)
    // Eight count advances at each divide ratio
    for (int d = 0; d < 4; d++) begin
      wr(STC_ADDR_CNT_LO, 8'h00);
      wr(STC_ADDR_CTRL, 8'(d << 4) | 8'h01);
      repeat (32 << d) @(posedge clock);
      wr(STC_ADDR_CTRL, 8'h00);
      rd(STC_ADDR_CNT_LO);
      `CHK(v inside {[8'h07:8'h09]}, 1'b1)
    end
    w = v;
    repeat (20) @(posedge clock);
    rd(STC_ADDR_CNT_LO);
    `CHK(v, w)
    // Pin counting, synchronised then bypassed
    for (int s = 0; s < 2; s++) begin
      ext.drive(1'b0);
      wr(STC_ADDR_CNT_LO, 8'h00);
      wr(STC_ADDR_CTRL, 8'(s << 2) | 8'h03);
      ext.drive(1'b1);
      ext.pulses(3);
      wr(STC_ADDR_CTRL, 8'h00);
      rd(STC_ADDR_CNT_LO);
      `CHK(v, 8'h03)
    end
    // Wrap, sticky flag, mask
    wr(STC_ADDR_ENABLES, 8'h01);
    wr(STC_ADDR_CNT_HI, 8'hFF);
    wr(STC_ADDR_CNT_LO, 8'hFE);
    wr(STC_ADDR_CTRL, 8'h01);
    repeat (20) @(posedge clock);
    wr(STC_ADDR_FLAGS, 8'hFF);
    rd(STC_ADDR_FLAGS);
    `CHK(v[0], 1'b1)
    `CHK(irq, 1'b1)
    rd(STC_ADDR_CNT_HI);
    `CHK(v, 8'h00)
    wr(STC_ADDR_ENABLES, 8'h00);
    @(negedge clock);
    `CHK(irq, 1'b0)
    wr(STC_ADDR_FLAGS, 8'h00);
    wr(STC_ADDR_ENABLES, 8'h01);
    rd(STC_ADDR_FLAGS);
    `CHK({v[0], irq}, 2'b00)
    // Special event clears count only in its own mode
    converterEnable <= 1'b1;
    wr(STC_ADDR_CNT_HI, 8'h12);
    trig(4'hA);
    `CHK(c, 1'b0)
    rd(STC_ADDR_CNT_HI);
    `CHK(v, 8'h12)
    trig(STC_MODE_SPECIAL);
    `CHK(c, 1'b1)
    rd(STC_ADDR_CNT_HI);
    `CHK(v, 8'h00)
    wr(STC_ADDR_CTRL, 8'h00);
    @(posedge clock);
    {addr, wrData, wrStrobe, compareMatch} <= {STC_ADDR_CNT_LO, 8'h55, 2'b11};
    @(posedge clock);
    {wrStrobe, compareMatch} <= 2'b00;
    rd(STC_ADDR_CNT_LO);
    `CHK(v, 8'h55)
    `CHK(crystalAmpEnable, 1'b0)
    @(posedge clock);
    {addr, wrData, wrStrobe} <= {STC_ADDR_CTRL, 8'hC4, 1'b1};
    @(posedge clock);
    {wrStrobe, rdStrobe} <= 2'b01;
    @(posedge clock);
    rdStrobe <= 1'b0;
    @(negedge clock);
    `CHK(rdData, 8'h04)
    endSim();
  end
endmodule : test_stc_timer
bind stc_timer stc_timer_asserts u_chk (.clock(clock), .rst(rst), .addr(addr),
  .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .matchModeSelect(matchModeSelect), .compareMatch(compareMatch),
  .converterEnable(converterEnable), .crystalAmpEnable(crystalAmpEnable),
  .conversionStart(conversionStart), .irq(irq));
`default_nettype wire
